// *** lds_host_model.sv ***
// serial master model: frames commands on a burst-only serial clock
// assumes the device samples on the rising serial clock, period 15 ns
`timescale 1ns/100ps
module lds_host_model (
	// serial pins driven toward the device
	output logic      sclk_o,
	output logic      load_strobe_n_o,
	output logic      serial_cmd_in_o,
	// serial pin from the device
	input  wire logic serial_chain_out_i
);

	initial begin
		sclk_o          = 1'b0;
		load_strobe_n_o = 1'b1;
		serial_cmd_in_o = 1'b0;
	end

	// one access: n bits msb first, then one idle rise or an 8-bit readout
	task automatic frame(input logic [15:0] w, input int n, input bit rd, output logic [7:0] q);
		q               = 8'h00;
		load_strobe_n_o = 1'b0;
		#30;
		for (int i = 0; i < n; i++) begin
			serial_cmd_in_o = w[15-i];
			#7.5 sclk_o = 1'b1;
			#7.5 sclk_o = 1'b0;
		end
		#5 load_strobe_n_o = 1'b1;
		serial_cmd_in_o = ~serial_cmd_in_o;
		#25;
		for (int i = 0; i < (rd ? 8 : 1); i++) begin
			sclk_o = 1'b1;
			#7.5 sclk_o = 1'b0;
			q = {q[6:0], serial_chain_out_i};
			#7.5;
		end
		#300;
	endtask
endmodule

// *** lds_link.sv ***
// serial-clock side: shifts command bits in, drives read data and chain output
// assumes the strobe and data are timed to the serial clock by the host
`timescale 1ns/100ps
module lds_link import lds_pkg::*; (
	// serial clock and reset
	input  wire logic       sclk_i,
	input  wire logic       arst_n_i,
	// serial pins
	input  wire logic       load_strobe_n_i,
	input  wire logic       serial_cmd_in_i,
	output logic            serial_chain_out_o,
	// toward the core
	input  wire logic [7:0] rdata_i,
	output lds_frame_t      frame_o
);
	logic [15:0] shift_reg;
	logic [4:0]  cnt_reg;
	logic        ld_prev_reg;
	logic [7:0]  rd_sh_reg;
	logic        rd_act_reg;
	logic        rd_start;

	assign frame_o.word = shift_reg;
	assign frame_o.cnt  = cnt_reg;
	assign rd_start = load_strobe_n_i && !ld_prev_reg && cnt_reg == CNT_RD && shift_reg[RD_OP_BIT];

	always_ff @(posedge sclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ld_prev_reg <= 1'b1;
		end else begin
			ld_prev_reg <= load_strobe_n_i;
		end
	end

	// first edge after strobe fall restarts the word
	always_ff @(posedge sclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shift_reg <= 16'h0000;
			cnt_reg   <= 5'h00;
		end else if (!load_strobe_n_i) begin
			if (ld_prev_reg) begin
				shift_reg <= {15'h0000, serial_cmd_in_i};
				cnt_reg   <= 5'h01;
			end else begin
				shift_reg <= {shift_reg[14:0], serial_cmd_in_i};
				cnt_reg   <= (cnt_reg == CNT_MAX) ? CNT_MAX : cnt_reg + 5'h01;
			end
		end
	end

	// read data out msb first while strobe high, else chain output
	always_ff @(posedge sclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_act_reg         <= 1'b0;
			rd_sh_reg          <= 8'h00;
			serial_chain_out_o <= 1'b0;
		end else if (!load_strobe_n_i) begin
			rd_act_reg         <= 1'b0;
			serial_chain_out_o <= shift_reg[15];
		end else if (rd_start) begin
			rd_act_reg         <= 1'b1;
			rd_sh_reg          <= {rdata_i[6:0], 1'b0};
			serial_chain_out_o <= rdata_i[DATA_HI];
		end else if (rd_act_reg) begin
			rd_sh_reg          <= {rd_sh_reg[6:0], 1'b0};
			serial_chain_out_o <= rd_sh_reg[DATA_HI];
		end
	end

	AST_SAMPLE_RISE: assert property (@(posedge sclk_i) disable iff (!arst_n_i)
		!load_strobe_n_i |=> shift_reg[0] == $past(serial_cmd_in_i))
		else $error("command bit not sampled on rising edge");
	AST_RD_ORDER: assert property (@(posedge sclk_i) disable iff (!arst_n_i)
		rd_start ##1 load_strobe_n_i |=> serial_chain_out_o == $past(rdata_i[6], 2))
		else $error("read data not shifted msb first");
	AST_RD_FIRST: assert property (@(posedge sclk_i) disable iff (!arst_n_i)
		rd_start |=> serial_chain_out_o == $past(rdata_i[DATA_HI]) && rd_act_reg)
		else $error("bit 7 not driven at first edge after strobe rise");
endmodule

// *** lds_pkg.sv ***
// constants and carrier types for the led driver serial port and shutdown control
// assumes a host that clocks command bits msb first on the serial clock
package lds_pkg;
	localparam int          WR_BITS     = 16;
	localparam int          RD_BITS     = 8;
	localparam int          CNT_W       = 5;
	localparam logic [4:0]  CNT_WR      = 5'h10;
	localparam logic [4:0]  CNT_RD      = 5'h08;
	localparam logic [4:0]  CNT_MAX     = 5'h1F;
	localparam int          OP_BIT      = 14;
	localparam int          RD_OP_BIT   = 6;
	localparam int          ADDR_HI     = 13;
	localparam int          ADDR_LO     = 8;
	localparam int          RADDR_HI    = 5;
	localparam int          DATA_HI     = 7;
	localparam int          NUM_DIGITS  = 8;
	localparam logic [7:0]  A_DIG0      = 8'h01;
	localparam logic [7:0]  A_DECODE    = 8'h09;
	localparam logic [7:0]  A_INTENS    = 8'h0A;
	localparam logic [7:0]  A_SCAN      = 8'h0B;
	localparam logic [7:0]  A_SHDN      = 8'h0C;
	localparam logic [7:0]  A_FEAT      = 8'h0E;
	localparam logic [7:0]  A_TEST      = 8'h0F;
	localparam int          SHDN_RUN    = 0;
	localparam int          SHDN_KEEP   = 7;
	localparam int          SCAN_HI     = 2;
	localparam logic [7:0]  RST_DIGIT   = 8'h00;
	localparam logic [7:0]  RST_DECODE  = 8'h00;
	localparam logic [7:0]  RST_INTENS  = 8'h00;
	localparam logic [7:0]  RST_SCAN    = 8'h00;
	localparam logic [7:0]  RST_SHDN    = 8'h00;
	localparam logic [7:0]  RST_FEAT    = 8'h00;
	localparam logic [7:0]  RST_TEST    = 8'h00;
	localparam logic [7:0]  RD_UNMAPPED = 8'h00;

	typedef struct packed {
		logic [7:0][7:0] digit;
		logic [7:0]      decode;
		logic [7:0]      intensity;
		logic [7:0]      scan_limit;
		logic [7:0]      feature;
		logic [7:0]      test;
		logic [7:0]      shutdown;
	} lds_cfg_t;

	typedef struct packed {
		logic [15:0] word;
		logic [4:0]  cnt;
	} lds_frame_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FRAME,
		ST_APPLY
	} lds_state_t;
endpackage

// *** lds_sync3.sv ***
// three-stage level synchroniser; output moves once stages two and three agree
// assumes d_i is asynchronous to clk_i
`timescale 1ns/100ps
module lds_sync3 import lds_pkg::*; #(
	parameter logic RST_VAL = 1'b1
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	// level in and out
	input  wire logic d_i,
	output logic      q_o
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
		end else begin
			s1_reg <= d_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q_o <= RST_VAL;
		end else if (s2_reg == s3_reg) begin
			q_o <= s3_reg;
		end
	end
endmodule

// *** lds_tb_top.sv ***
// self-checking bench for the serial port, register file and shutdown control
// assumes the host model drives the serial pins; core inputs change on falling clk
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin num_errors++; \
	$display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module lds_tb_top import lds_pkg::*;;
	logic       clk_i;
	logic       arst_n_i;
	logic       hw_clear_low_i;
	wire logic  serial_chain_out;
	wire logic  sclk;
	wire logic  load_strobe_n;
	wire logic  serial_cmd_in;
	lds_cfg_t   cfg;
	logic       blank;
	logic [7:0] digit_en;
	lds_cfg_t   e;
	logic [7:0] q;
	logic [7:0] r;
	int         seed;
	int         num_errors;
	int         num_checks;

	lds_host_model u_lds_host_model (
		.sclk_o             (sclk),
		.load_strobe_n_o    (load_strobe_n),
		.serial_cmd_in_o    (serial_cmd_in),
		.serial_chain_out_i (serial_chain_out)
	);
	lds_top u_lds_top (
		.clk_i              (clk_i),
		.arst_n_i           (arst_n_i),
		.sclk_i             (sclk),
		.load_strobe_n_i    (load_strobe_n),
		.serial_cmd_in_i    (serial_cmd_in),
		.serial_chain_out_o (serial_chain_out),
		.hw_clear_low_i     (hw_clear_low_i),
		.cfg_o              (cfg),
		.blank_o            (blank),
		.digit_en_o         (digit_en)
	);

	always #25 clk_i = ~clk_i;

	function automatic lds_cfg_t apply(lds_cfg_t c, logic [7:0] a, logic [7:0] d);
		case (a)
			A_DECODE: c.decode = d;
			A_INTENS: c.intensity = d;
			A_SCAN:   c.scan_limit = d;
			A_FEAT:   c.feature = d;
			A_TEST:   c.test = d;
			A_SHDN: begin
				if (c.shutdown[SHDN_RUN] != d[SHDN_RUN] && !d[SHDN_KEEP])
					c.feature = 8'h00;
				c.shutdown = d;
			end
			default: if (a >= A_DIG0 && a < A_DIG0 + 8'h08) c.digit[a-A_DIG0] = d;
		endcase
		return c;
	endfunction

	function automatic logic [7:0] rd_exp(lds_cfg_t c, logic [7:0] a);
		logic [7:0] v;
		v = RD_UNMAPPED;
		case (a)
			A_DECODE: v = c.decode;
			A_INTENS: v = c.intensity;
			A_SCAN:   v = c.scan_limit;
			A_FEAT:   v = c.feature;
			A_TEST:   v = c.test;
			A_SHDN:   v = c.shutdown;
			default:  if (a >= A_DIG0 && a < A_DIG0 + 8'h08) v = c.digit[a-A_DIG0];
		endcase
		return v;
	endfunction

	function automatic logic [7:0] en_exp(lds_cfg_t c);
		return c.shutdown[SHDN_RUN] ? (8'hFF >> (3'h7 - c.scan_limit[SCAN_HI:0])) : 8'h00;
	endfunction

	task automatic chk();
		repeat (6) @(negedge clk_i);
		`CHK("cfg", e, cfg)
		`CHK("blank", ~e.shutdown[SHDN_RUN], blank)
		`CHK("digit_en", en_exp(e), digit_en)
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_lds_host_model.frame({seed[0], 1'b0, a[5:0], d}, 16, 1'b0, q);
		e = apply(e, a, d);
		chk();
	endtask

	task automatic rd(input logic [7:0] a);
		u_lds_host_model.frame({2'b01, a[5:0], 8'h00}, 8, 1'b1, q);
		`CHK("rdata", rd_exp(e, a), q)
	endtask

	task automatic clear_pin(input logic lvl);
		@(negedge clk_i);
		hw_clear_low_i = lvl;
		if (!lvl) begin
			if (e.shutdown[SHDN_RUN] && !e.shutdown[SHDN_KEEP])
				e.feature = 8'h00;
			e.shutdown[SHDN_RUN] = 1'b0;
		end
		chk();
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		clk_i          = 1'b0;
		arst_n_i       = 1'b0;
		hw_clear_low_i = 1'b1;
		seed           = 56640;
		num_errors     = 0;
		num_checks     = 0;
		e              = '0;
		repeat (4) @(negedge clk_i);
		arst_n_i = 1'b1;
		chk();
		`CHK("scan_default", RST_SCAN, cfg.scan_limit)
		$display("test reset defaults done");
		for (int i = 0; i < 8; i++) begin
			wr(A_DIG0 + i[7:0], $random(seed));
			rd(A_DIG0 + i[7:0]);
		end
		$display("test digit registers done");
		wr(A_SCAN, $random(seed));
		wr(A_SHDN, 8'h01);
		// codes 00, 01, 80, 81: every one changes run, keep bit clear then set
		for (int k = 0; k < 4; k++) begin
			r = {k[1], 6'h00, k[0]};
			wr(A_FEAT, $random(seed));
			wr(A_SHDN, r);
			rd(A_FEAT);
		end
		$display("test shutdown codes done");
		for (int k = 0; k < 2; k++) begin
			wr(A_SHDN, k ? 8'h01 : 8'h81);
			wr(A_FEAT, $random(seed));
			clear_pin(1'b0);
			clear_pin(1'b1);
		end
		$display("test clear pin done");
		u_lds_host_model.frame({2'b00, A_DIG0[5:0], ~e.digit[0]}, 15, 1'b0, q);
		chk();
		u_lds_host_model.frame({2'b01, A_DIG0[5:0], ~e.digit[0]}, 16, 1'b0, q);
		chk();
		rd(8'h0D);
		wr(A_SHDN, 8'h81);
		wr(A_SCAN, RST_SCAN);
		$display("test refused frames done");
		repeat (20) begin
			r = $random(seed);
			wr({4'h0, r[3:0]}, $random(seed));
			rd({4'h0, r[7:4]});
		end
		$display("test random traffic done");
		@(negedge clk_i);
		arst_n_i = 1'b0;
		e        = '0;
		repeat (4) @(negedge clk_i);
		arst_n_i = 1'b1;
		chk();
		wr(A_DIG0, 8'hA5);
		rd(A_DIG0);
		$display("test mid-run reset done");
		wrap_up();
	end
endmodule

// *** lds_top.sv ***
// led driver serial command port, register file and shutdown control
// assumes sclk_i is the host's serial clock, stopped or free outside frames
`timescale 1ns/100ps
module lds_top import lds_pkg::*; (
	// core clock and reset
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	// serial port
	input  wire logic       sclk_i,
	input  wire logic       load_strobe_n_i,
	input  wire logic       serial_cmd_in_i,
	output logic            serial_chain_out_o,
	// hardware clear pin
	input  wire logic       hw_clear_low_i,
	// register contents and drive control
	output lds_cfg_t        cfg_o,
	output logic            blank_o,
	output logic [7:0]      digit_en_o
);
	lds_frame_t  frame;
	logic [7:0]  rdata;
	logic        ld_sync;
	logic        clr_sync;
	lds_state_t  state_reg;
	lds_state_t  state_next;
	logic [7:0]  wr_addr;
	logic [7:0]  wr_data;
	logic        wr_en;
	logic        shdn_wr;
	logic [7:0]  shdn_next;
	logic        shdn_change;
	logic [7:0]  rd_addr;
	logic [7:0]  digit_en_next;

	lds_link u_link (
		.sclk_i             (sclk_i),
		.arst_n_i           (arst_n_i),
		.load_strobe_n_i    (load_strobe_n_i),
		.serial_cmd_in_i    (serial_cmd_in_i),
		.serial_chain_out_o (serial_chain_out_o),
		.rdata_i            (rdata),
		.frame_o            (frame)
	);

	lds_sync3 #(
		.RST_VAL (1'b1)
	) u_ld_sync (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.d_i      (load_strobe_n_i),
		.q_o      (ld_sync)
	);

	lds_sync3 #(
		.RST_VAL (1'b1)
	) u_clr_sync (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.d_i      (hw_clear_low_i),
		.q_o      (clr_sync)
	);

	// access sequencing: strobe low opens, strobe high applies
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (!ld_sync) begin
					state_next = ST_FRAME;
				end
			end
			ST_FRAME: begin
				if (ld_sync) begin
					state_next = ST_APPLY;
				end
			end
			ST_APPLY: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// frame is stable here: serial clock edges only shift while strobe low
	assign wr_addr = {2'b00, frame.word[ADDR_HI:ADDR_LO]};
	assign wr_data = frame.word[DATA_HI:0];
	assign wr_en   = state_reg == ST_APPLY && frame.cnt == CNT_WR
		&& !frame.word[OP_BIT];

	// clear pin behaves as a shutdown write, keeping the keep bit
	always_comb begin
		shdn_wr   = 1'b0;
		shdn_next = cfg_o.shutdown;
		if (!clr_sync) begin
			shdn_wr   = 1'b1;
			shdn_next = cfg_o.shutdown;
			shdn_next[SHDN_RUN] = 1'b0;
		end else if (wr_en && wr_addr == A_SHDN) begin
			shdn_wr   = 1'b1;
			shdn_next = wr_data;
		end
	end

	assign shdn_change = shdn_wr && shdn_next[SHDN_RUN] != cfg_o.shutdown[SHDN_RUN];

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg_o.shutdown <= RST_SHDN;
		end else if (shdn_wr) begin
			cfg_o.shutdown <= shdn_next;
		end
	end

	// feature register cleared on mode change unless keep bit set
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg_o.feature <= RST_FEAT;
		end else if (shdn_change && !shdn_next[SHDN_KEEP]) begin
			cfg_o.feature <= RST_FEAT;
		end else if (wr_en && wr_addr == A_FEAT) begin
			cfg_o.feature <= wr_data;
		end
	end

	// digit data is untouched by shutdown
	generate
		for (genvar i = 0; i < NUM_DIGITS; i++) begin : g_digit
			always_ff @(posedge clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					cfg_o.digit[i] <= RST_DIGIT;
				end else if (wr_en && wr_addr == A_DIG0 + 8'(i)) begin
					cfg_o.digit[i] <= wr_data;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg_o.decode     <= RST_DECODE;
			cfg_o.intensity  <= RST_INTENS;
			cfg_o.scan_limit <= RST_SCAN;
			cfg_o.test       <= RST_TEST;
		end else if (wr_en) begin
			case (wr_addr)
				A_DECODE: begin
					cfg_o.decode <= wr_data;
				end
				A_INTENS: begin
					cfg_o.intensity <= wr_data;
				end
				A_SCAN: begin
					cfg_o.scan_limit <= wr_data;
				end
				A_TEST: begin
					cfg_o.test <= wr_data;
				end
				default: begin
					cfg_o.test <= cfg_o.test;
				end
			endcase
		end
	end

	// read mux; registers change only on applied writes or the clear pin, so quasi-static
	assign rd_addr = {2'b00, frame.word[RADDR_HI:0]};

	always_comb begin
		rdata = RD_UNMAPPED;
		case (rd_addr)
			A_DECODE: rdata = cfg_o.decode;
			A_INTENS: rdata = cfg_o.intensity;
			A_SCAN:   rdata = cfg_o.scan_limit;
			A_SHDN:   rdata = cfg_o.shutdown;
			A_FEAT:   rdata = cfg_o.feature;
			A_TEST:   rdata = cfg_o.test;
			default: begin
				if (rd_addr >= A_DIG0 && rd_addr < A_DIG0 + 8'(NUM_DIGITS)) begin
					rdata = cfg_o.digit[3'(rd_addr - A_DIG0)];
				end
			end
		endcase
	end

	// drivers off in shutdown, else digits up to scan limit
	generate
		for (genvar d = 0; d < NUM_DIGITS; d++) begin : g_den
			assign digit_en_next[d] = cfg_o.shutdown[SHDN_RUN]
				&& 3'(d) <= cfg_o.scan_limit[SCAN_HI:0];
		end
	endgenerate

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			blank_o    <= 1'b1;
			digit_en_o <= 8'h00;
		end else begin
			blank_o    <= !cfg_o.shutdown[SHDN_RUN];
			digit_en_o <= digit_en_next;
		end
	end

	AST_APPLY_ON_RISE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		state_reg == ST_FRAME && ld_sync |=> state_reg == ST_APPLY ##1 state_reg == ST_IDLE)
		else $error("access not applied after strobe rise");
	AST_CLEAR_SHDN: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!clr_sync |=> !cfg_o.shutdown[SHDN_RUN] ##1 blank_o && digit_en_o == 8'h00)
		else $error("clear pin did not force shutdown");
	AST_CLEAR_KEEPS_BIT7: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!clr_sync |=> cfg_o.shutdown[SHDN_KEEP] == $past(cfg_o.shutdown[SHDN_KEEP]))
		else $error("clear pin write altered keep bit");
	AST_RELEASE_STAYS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		$rose(clr_sync) && !(wr_en && wr_addr == A_SHDN) |=> !cfg_o.shutdown[SHDN_RUN])
		else $error("clear release left shutdown by itself");
	AST_BLANKED: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!cfg_o.shutdown[SHDN_RUN] |=> blank_o && digit_en_o == 8'h00)
		else $error("drivers active during shutdown");
	AST_FEAT_CLEARED: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		shdn_change && !shdn_next[SHDN_KEEP] |=> cfg_o.feature == RST_FEAT)
		else $error("feature not cleared on mode change");
	AST_FEAT_KEPT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		shdn_change && shdn_next[SHDN_KEEP] |=> $stable(cfg_o.feature))
		else $error("feature changed despite keep bit");
	AST_DIGIT_HELD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!(wr_en && wr_addr >= A_DIG0 && wr_addr < A_DECODE) |=> $stable(cfg_o.digit))
		else $error("digit data changed without a digit write");
	AST_BAD_COUNT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		state_reg == ST_APPLY && frame.cnt != CNT_WR && clr_sync |=> $stable(cfg_o))
		else $error("short or long write changed registers");
	AST_READ_NO_WRITE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		state_reg == ST_APPLY && frame.word[OP_BIT] && clr_sync |=> $stable(cfg_o))
		else $error("read command wrote a register");
	AST_SCAN_MASK: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		cfg_o.shutdown[SHDN_RUN] && cfg_o.scan_limit == RST_SCAN |=> digit_en_o == 8'h01)
		else $error("default scan limit not single digit");
	AST_OPEN_ON_FALL: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		state_reg == ST_IDLE && !ld_sync |=> state_reg == ST_FRAME)
		else $error("access not opened after strobe fall");
	AST_SHDN_WRITE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		wr_en && wr_addr == A_SHDN && clr_sync |=> cfg_o.shutdown == $past(wr_data))
		else $error("shutdown register write not taken");
	AST_WRITE_LANDS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		wr_en && wr_addr == A_INTENS |=> cfg_o.intensity == $past(wr_data))
		else $error("addressed register not written");
	AST_RUN_DRIVES: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		cfg_o.shutdown[SHDN_RUN] |=> !blank_o && digit_en_o[0])
		else $error("display blanked in normal operation");
endmodule
